// *** logic/mpbs_pkg.sv ***
package mpbs_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_LOCAL_ID = 32'hFEE0_0020;
  localparam logic [31:0] ADDR_SPUR_VEC = 32'hFEE0_00F0;
  localparam logic [31:0] ADDR_CMD_LOW = 32'hFEE0_0300;
  localparam logic [31:0] ADDR_ERR_VEC = 32'hFEE0_0370;

  // Field positions and reset values
  localparam int SPUR_EN_BIT = 8;
  localparam int ID_BYTE_POS = 24;
  localparam logic [31:0] SPUR_RESET = 32'h0000_0000;
  localparam logic [31:0] ERR_VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] ID_READ_MASK = 32'hFF00_0000;

  // Command encodings
  localparam logic [31:0] CMD_INIT_ALL = 32'h000C_4500;
  localparam logic [23:0] CMD_STARTUP_HI = 24'h00_0C46;

  // Start addresses
  localparam logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0;

  // Cycle counts
  localparam int BUILTIN_SELF_TEST_CYCLES = 64;
  localparam int QUIET_CYCLES = 16;

  typedef enum logic [1:0] {
    MPBS_MSG_BOOT_SEL,
    MPBS_MSG_FINAL_SEL,
    MPBS_MSG_INIT,
    MPBS_MSG_STARTUP
  } mpbs_msg_kind_t;

  typedef struct packed {
    mpbs_msg_kind_t kind;
    logic [7:0] src;
    logic [7:0] vec;
  } mpbs_msg_t;

  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mpbs_reg_req_t;

  // Lower ID wins, so ID 0 becomes the default bootstrap processor
  function automatic logic [7:0] mpbs_prio(input logic [31:0] id);
    mpbs_prio = 8'hFF - id[7:0];
  endfunction : mpbs_prio

  // Startup page address: vector in bits 19:12
  function automatic logic [31:0] mpbs_start_addr(input logic [7:0] vv);
    mpbs_start_addr = {12'h000, vv, 12'h000};
  endfunction : mpbs_start_addr

endpackage : mpbs_pkg

// *** logic/mpbs_builtin_self_test.sv ***
`timescale 1ns/1ps
module mpbs_builtin_self_test #(
  parameter int CYCLES = mpbs_pkg::BUILTIN_SELF_TEST_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  output logic done
);
  import mpbs_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic run_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= '0;
      done <= 1'b0;
    end else if (start && !run_r && !done) begin
      run_r <= 1'b1;
      cnt_r <= '0;
    end else if (run_r) begin
      if (cnt_r == LAST) begin
        run_r <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

endmodule : mpbs_builtin_self_test

// *** logic/mpbs_quiet_detect.sv ***
`timescale 1ns/1ps
module mpbs_quiet_detect #(
  parameter int QUIET = mpbs_pkg::QUIET_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Watch window and pin
  input wire logic arm,
  input wire logic line_pin,
  output logic quiet
);
  import mpbs_pkg::*;

  localparam int CW = $clog2(QUIET + 1);
  localparam logic [CW-1:0] LAST = CW'(QUIET - 1);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic seen_r;
  logic [CW-1:0] still_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= line_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Quiet only after the line has toggled at least once
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      seen_r <= 1'b0;
      still_r <= '0;
      quiet <= 1'b0;
    end else if (!arm) begin
      still_r <= '0;
      quiet <= 1'b0;
    end else if (sync2_r != prev_r) begin
      seen_r <= 1'b1;
      still_r <= '0;
      quiet <= 1'b0;
    end else if (seen_r && !quiet) begin
      if (still_r == LAST) begin
        quiet <= 1'b1;
      end else begin
        still_r <= still_r + CW'(1);
      end
    end
  end

endmodule : mpbs_quiet_detect

// *** logic/mpbs_boot_select.sv ***
`timescale 1ns/1ps
module mpbs_boot_select #(
  parameter int BUILTIN_SELF_TEST_LEN = mpbs_pkg::BUILTIN_SELF_TEST_CYCLES,
  parameter int QUIET_LEN = mpbs_pkg::QUIET_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Straps
  input wire logic [31:0] strap_id,
  input wire logic strap_ext_topology,
  input wire logic strap_new_gen,
  // Register port
  input wire logic reg_valid,
  input wire mpbs_pkg::mpbs_reg_req_t reg_req,
  output logic reg_ready,
  output logic reg_rvalid,
  output logic [31:0] reg_rdata,
  // System bus selection
  input wire logic bus_not_ready_line,
  output logic nop_req,
  output logic [7:0] nop_prio,
  input wire logic nop_won,
  input wire logic nop_lost,
  // Message bus
  output logic msg_tx_valid,
  output mpbs_pkg::mpbs_msg_t msg_tx,
  input wire logic msg_tx_ready,
  input wire logic msg_rx_valid,
  input wire mpbs_pkg::mpbs_msg_t msg_rx,
  // Core side
  input wire logic halt_req,
  input wire logic nmi_req,
  input wire logic smi_req,
  input wire logic intr_req,
  input wire logic snoop_req,
  input wire logic stop_clock_request_line,
  output logic snoop_ack,
  output logic stop_clock_ack,
  output logic wake,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  // Status
  output logic bootstrap_processor,
  output logic application_processor,
  output logic halted,
  output logic unit_enabled,
  output logic [31:0] local_id,
  output logic [7:0] error_vector
);
  import mpbs_pkg::*;

  typedef enum logic [3:0] {
    ST_ID,
    ST_BUILTIN_SELF_TEST,
    ST_SEL_NEW,
    ST_SEL_OLD,
    ST_WAIT_FINAL,
    ST_BOOT_RUN,
    ST_WAIT_START,
    ST_AP_RUN,
    ST_HALTED
  } mpbs_state_t;

  mpbs_state_t state_r;
  mpbs_state_t state_nxt;
  logic ext_r;
  logic new_gen_r;
  logic [31:0] id_r;
  logic bsp_r;
  logic [31:0] spur_r;
  logic [31:0] err_r;
  logic sent_sel_r;
  logic builtin_self_test_done;
  logic quiet;
  logic wr_hit;
  logic rx_own;
  logic rx_init;
  logic rx_start;
  logic rx_bsel;
  logic rx_final;
  logic cmd_init;
  logic cmd_start;
  logic tx_free;

  mpbs_builtin_self_test #(
    .CYCLES(BUILTIN_SELF_TEST_LEN)
  ) u_builtin_self_test (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(state_r == ST_BUILTIN_SELF_TEST),
    .done(builtin_self_test_done)
  );

  mpbs_quiet_detect #(
    .QUIET(QUIET_LEN)
  ) u_quiet (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .arm(state_r == ST_SEL_NEW),
    .line_pin(bus_not_ready_line),
    .quiet(quiet)
  );

  assign reg_ready = 1'b1;
  assign wr_hit = reg_valid && reg_req.wr;
  assign rx_own = msg_rx.src == id_r[7:0];
  assign rx_init = msg_rx_valid && msg_rx.kind == MPBS_MSG_INIT && !rx_own;
  assign rx_start = msg_rx_valid && msg_rx.kind == MPBS_MSG_STARTUP;
  assign rx_bsel = msg_rx_valid && msg_rx.kind == MPBS_MSG_BOOT_SEL;
  assign rx_final = msg_rx_valid && msg_rx.kind == MPBS_MSG_FINAL_SEL;
  assign tx_free = !msg_tx_valid || msg_tx_ready;
  assign cmd_init = wr_hit && reg_req.addr == ADDR_CMD_LOW &&
                    reg_req.wdata == CMD_INIT_ALL;
  assign cmd_start = wr_hit && reg_req.addr == ADDR_CMD_LOW &&
                      reg_req.wdata[31:8] == CMD_STARTUP_HI;

  // unique ID assignment, straps caught once after reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      id_r <= '0;
      ext_r <= 1'b0;
      new_gen_r <= 1'b0;
    end else if (state_r == ST_ID) begin
      id_r <= strap_ext_topology ? strap_id : {24'h000000, strap_id[7:0]};
      ext_r <= strap_ext_topology;
      new_gen_r <= strap_new_gen;
    end else if (wr_hit && reg_req.addr == ADDR_LOCAL_ID) begin
      id_r <= {24'h000000, reg_req.wdata[ID_BYTE_POS +: 8]};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      spur_r <= SPUR_RESET;
    end else if (wr_hit && reg_req.addr == ADDR_SPUR_VEC) begin
      spur_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      err_r <= ERR_VEC_RESET;
    end else if (wr_hit && reg_req.addr == ADDR_ERR_VEC) begin
      err_r <= reg_req.wdata;
    end
  end

  // Read data, one cycle after the request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rvalid <= 1'b0;
      reg_rdata <= '0;
    end else begin
      reg_rvalid <= reg_valid && !reg_req.wr;
      case (reg_req.addr)
        ADDR_LOCAL_ID: reg_rdata <= {id_r[7:0], 24'h000000} & ID_READ_MASK;
        ADDR_SPUR_VEC: reg_rdata <= spur_r;
        ADDR_ERR_VEC: reg_rdata <= err_r;
        default: reg_rdata <= '0;
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ID: state_nxt = ST_BUILTIN_SELF_TEST;
      ST_BUILTIN_SELF_TEST: if (builtin_self_test_done) begin
        state_nxt = new_gen_r ? ST_SEL_NEW : ST_SEL_OLD;
      end
      ST_SEL_NEW: if (nop_req && nop_won) begin
        state_nxt = ST_BOOT_RUN;
      end else if (nop_req && nop_lost) begin
        state_nxt = ST_WAIT_START;
      end
      ST_SEL_OLD: if (rx_bsel) begin
        state_nxt = ST_WAIT_FINAL;
      end
      ST_WAIT_FINAL: if (rx_final) begin
        state_nxt = bsp_r ? ST_BOOT_RUN : ST_WAIT_START;
      end
      ST_BOOT_RUN: if (rx_init) begin
        state_nxt = ST_BOOT_RUN;
      end
      ST_WAIT_START: if (rx_start) begin
        state_nxt = ST_AP_RUN;
      end
      ST_AP_RUN: if (rx_init) begin
        state_nxt = ST_WAIT_START;
      end else if (halt_req) begin
        state_nxt = ST_HALTED;
      end
      // wake only on init, NMI, SYSTEM_MANAGEMENT_INTERRUPT
      ST_HALTED: if (rx_init) begin
        state_nxt = bsp_r ? ST_BOOT_RUN : ST_WAIT_START;
      end else if (nmi_req || smi_req) begin
        state_nxt = ST_AP_RUN;
      end
      default: state_nxt = ST_ID;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_ID;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bootstrap flag, set once per reset and kept across inits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bsp_r <= 1'b0;
    end else if (state_r == ST_SEL_NEW && nop_req && nop_won) begin
      bsp_r <= 1'b1;
    end else if (state_r == ST_SEL_OLD && rx_bsel && rx_own) begin
      bsp_r <= 1'b1;
    end
  end

  // request no-op cycle once line is quiet
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      nop_req <= 1'b0;
      nop_prio <= '0;
    end else begin
      nop_req <= state_nxt == ST_SEL_NEW && quiet;
      nop_prio <= mpbs_prio(id_r);
    end
  end

  // Message transmitter, one slot; command writes while busy are dropped
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      msg_tx_valid <= 1'b0;
      msg_tx <= '0;
      sent_sel_r <= 1'b0;
    end else if (tx_free) begin
      msg_tx_valid <= 1'b0;
      if (state_r == ST_SEL_OLD && !sent_sel_r && !rx_bsel) begin
        msg_tx_valid <= 1'b1;
        msg_tx <= '{MPBS_MSG_BOOT_SEL, id_r[7:0], 8'h00};
        sent_sel_r <= 1'b1;
      end else if (state_r == ST_WAIT_FINAL && bsp_r && sent_sel_r) begin
        msg_tx_valid <= 1'b1;
        msg_tx <= '{MPBS_MSG_FINAL_SEL, id_r[7:0], 8'h00};
        sent_sel_r <= 1'b0;
      end else if (cmd_init) begin
        msg_tx_valid <= 1'b1;
        msg_tx <= '{MPBS_MSG_INIT, id_r[7:0], 8'h00};
      end else if (cmd_start) begin
        msg_tx_valid <= 1'b1;
        msg_tx <= '{MPBS_MSG_STARTUP, id_r[7:0], reg_req.wdata[7:0]};
      end
    end
  end

  // Code fetch start pulses
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_valid <= 1'b0;
      fetch_addr <= '0;
    end else begin
      fetch_valid <= 1'b0;
      if (state_nxt == ST_BOOT_RUN &&
          (state_r != ST_BOOT_RUN || rx_init)) begin
        fetch_valid <= 1'b1;
        fetch_addr <= RESET_VECTOR;
      end else if (state_r == ST_WAIT_START && rx_start) begin
        fetch_valid <= 1'b1;
        fetch_addr <= mpbs_start_addr(msg_rx.vec);
      end
    end
  end

  // snoops and stop-clock always serviced; maskable ignored when halted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      snoop_ack <= 1'b0;
      stop_clock_ack <= 1'b0;
      wake <= 1'b0;
      halted <= 1'b0;
    end else begin
      snoop_ack <= snoop_req;
      stop_clock_ack <= stop_clock_request_line;
      wake <= state_r == ST_HALTED && state_nxt != ST_HALTED;
      halted <= state_nxt == ST_HALTED;
    end
  end

  assign bootstrap_processor = bsp_r;
  assign application_processor = !bsp_r &&
    (state_r == ST_WAIT_START || state_r == ST_AP_RUN ||
     state_r == ST_HALTED);
  assign unit_enabled = spur_r[SPUR_EN_BIT];
  assign local_id = ext_r ? id_r : {24'h000000, id_r[7:0]};
  assign error_vector = err_r[7:0];
endmodule : mpbs_boot_select

// *** testbench/mpbs_props.sv ***
`timescale 1ns/1ps
module mpbs_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_valid,
  input wire mpbs_pkg::mpbs_reg_req_t reg_req,
  input wire logic reg_rvalid,
  input wire logic [31:0] reg_rdata,
  // Selection and messages
  input wire logic nop_req,
  input wire logic [7:0] nop_prio,
  input wire logic nop_won,
  input wire logic nop_lost,
  input wire logic msg_rx_valid,
  // Core side
  input wire logic nmi_req,
  input wire logic smi_req,
  input wire logic intr_req,
  input wire logic wake,
  input wire logic halted,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  // Status
  input wire logic bootstrap_processor,
  input wire logic application_processor,
  input wire logic unit_enabled,
  input wire logic [31:0] local_id,
  input wire logic [7:0] error_vector
);
  import mpbs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rd_id, wr_sp, wr_ev;
  assign rd_id = reg_valid && !reg_req.wr && reg_req.addr == ADDR_LOCAL_ID;
  assign wr_sp = reg_valid && reg_req.wr && reg_req.addr == ADDR_SPUR_VEC;
  assign wr_ev = reg_valid && reg_req.wr && reg_req.addr == ADDR_ERR_VEC;
  id_read_a: assert property (
    rd_id |=> reg_rvalid && reg_rdata == {local_id[7:0], 24'h0})
    else $error("ID read wrong");
  prio_from_id_a: assert property (
    nop_req |-> nop_prio == 8'hFF - local_id[7:0])
    else $error("priority not from ID");
  win_fetch_a: assert property (
    nop_req && nop_won |=> ##[0:1] fetch_valid && fetch_addr == RESET_VECTOR)
    else $error("winner did not fetch reset vector");
  lose_ap_a: assert property (
    nop_req && nop_lost |=> ##[0:2] application_processor
      && !bootstrap_processor)
    else $error("loser not waiting");
  ap_page_a: assert property (
    fetch_valid && application_processor
      |-> fetch_addr[31:20] == 12'h0 && fetch_addr[11:0] == 12'h0)
    else $error("startup page out of range");
  intr_ignored_a: assert property (
    halted && intr_req && !nmi_req && !smi_req && !msg_rx_valid
      |=> !wake)
    else $error("halted woke on maskable request");
  spur_enable_a: assert property (
    wr_sp |=> unit_enabled == $past(reg_req.wdata[SPUR_EN_BIT]))
    else $error("enable bit not taken");
  err_vector_a: assert property (
    wr_ev |=> error_vector == $past(reg_req.wdata[7:0]))
    else $error("error vector not taken");
  cover property (nop_req && nop_won);
  cover property (nop_req && nop_lost);
  cover property (halted && intr_req);
endmodule : mpbs_props

bind mpbs_boot_select mpbs_props u_props (
  .clk_sys, .sys_rst, .reg_valid, .reg_req, .reg_rvalid, .reg_rdata,
  .nop_req, .nop_prio, .nop_won, .nop_lost, .msg_rx_valid, .nmi_req,
  .smi_req, .intr_req, .wake, .halted, .fetch_valid, .fetch_addr,
  .bootstrap_processor, .application_processor, .unit_enabled,
  .local_id, .error_vector);

// *** testbench/mpbs_peer.sv ***
`timescale 1ns/1ps
module mpbs_peer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Selection bus
  input wire logic [7:0] peer_prio,
  input wire logic nop_req,
  input wire logic [7:0] nop_prio,
  output logic bus_not_ready_line,
  output logic nop_won,
  output logic nop_lost,
  // Message bus
  input wire logic msg_tx_valid,
  input wire mpbs_pkg::mpbs_msg_t msg_tx,
  output logic msg_tx_ready,
  output logic msg_rx_valid,
  output mpbs_pkg::mpbs_msg_t msg_rx
);
  import mpbs_pkg::*;
  logic [4:0] cnt_r;
  logic ans_r, echo;
  assign echo = msg_tx_valid && msg_tx_ready
    && msg_tx.kind inside {MPBS_MSG_BOOT_SEL, MPBS_MSG_FINAL_SEL};
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 5'h00;
      bus_not_ready_line <= 1'b1;
    end else if (cnt_r != 5'h1F) begin
      cnt_r <= cnt_r + 5'h01;
      bus_not_ready_line <= (cnt_r < 5'h0C) ? ~bus_not_ready_line : 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ans_r <= 1'b0;
      nop_won <= 1'b0;
      nop_lost <= 1'b0;
    end else begin
      ans_r <= ans_r | nop_req;
      nop_won <= nop_req && !ans_r && (nop_prio > peer_prio);
      nop_lost <= nop_req && !ans_r && (nop_prio <= peer_prio);
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      msg_tx_ready <= 1'b0;
      msg_rx_valid <= 1'b0;
      msg_rx <= '0;
    end else begin
      msg_tx_ready <= ~msg_tx_ready;
      msg_rx_valid <= echo;
      msg_rx <= echo ? msg_tx : ~msg_rx;
    end
  end
endmodule : mpbs_peer

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import mpbs_pkg::*;
  logic clk_sys, sys_rst, strap_ext_topology, strap_new_gen, reg_valid;
  logic reg_ready, reg_rvalid, bus_not_ready_line, nop_req, nop_won;
  logic nop_lost, msg_tx_valid, msg_tx_ready, msg_rx_valid, p_rx_v, t_rx_v;
  logic halt_req, nmi_req, smi_req, intr_req, snoop_req, snoop_ack, wake;
  logic stop_clock_request_line, stop_clock_ack, fetch_valid, halted;
  logic bootstrap_processor, application_processor, unit_enabled;
  logic [31:0] strap_id, reg_rdata, fetch_addr, local_id, last_fa;
  logic [7:0] nop_prio, error_vector, peer_prio;
  mpbs_reg_req_t reg_req;
  mpbs_msg_t msg_tx, msg_rx, p_rx, t_rx, last_tx;
  int fail_count, num_checks, n_f, n_tx, n_w;
  assign msg_rx_valid = p_rx_v | t_rx_v;
  assign msg_rx = t_rx_v ? t_rx : p_rx;
  mpbs_boot_select #(.BUILTIN_SELF_TEST_LEN(4), .QUIET_LEN(3)) DUT (
    .clk_sys, .sys_rst, .strap_id, .strap_ext_topology, .strap_new_gen,
    .reg_valid, .reg_req, .reg_ready, .reg_rvalid, .reg_rdata,
    .bus_not_ready_line, .nop_req, .nop_prio, .nop_won, .nop_lost,
    .msg_tx_valid, .msg_tx, .msg_tx_ready, .msg_rx_valid, .msg_rx,
    .halt_req, .nmi_req, .smi_req, .intr_req, .snoop_req,
    .stop_clock_request_line, .snoop_ack, .stop_clock_ack, .wake,
    .fetch_valid, .fetch_addr, .bootstrap_processor,
    .application_processor, .halted, .unit_enabled, .local_id,
    .error_vector);
  mpbs_peer PEER (
    .clk_sys, .sys_rst, .peer_prio, .nop_req, .nop_prio,
    .bus_not_ready_line, .nop_won, .nop_lost, .msg_tx_valid, .msg_tx,
    .msg_tx_ready, .msg_rx_valid(p_rx_v), .msg_rx(p_rx));
  always @(posedge clk_sys) begin
    if (fetch_valid === 1'b1) begin
      n_f <= n_f + 1;
      last_fa <= fetch_addr;
    end
    if (msg_tx_valid && msg_tx_ready) begin
      n_tx <= n_tx + 1;
      last_tx <= msg_tx;
    end
    if (wake === 1'b1) n_w <= n_w + 1;
  end
  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, dd);
    reg_valid <= 1'b1;
    reg_req <= '{1'b1, a, dd};
    @(posedge clk_sys);
    reg_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : wr
  task automatic rchk(input string n, input logic [31:0] a, exp);
    reg_valid <= 1'b1;
    reg_req <= '{1'b0, a, 32'h0};
    @(posedge clk_sys);
    reg_valid <= 1'b0;
    #1;
    chk("rvalid", 32'({reg_ready, reg_rvalid}), 32'h3);
    chk(n, reg_rdata, exp);
    @(posedge clk_sys);
  endtask : rchk
  task automatic send(input mpbs_msg_kind_t k, input logic [7:0] v);
    t_rx_v <= 1'b1;
    t_rx <= '{k, 8'h05, v};
    @(posedge clk_sys);
    t_rx_v <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic wait_n(ref int c, input int n);
    for (int i = 0; i < 300 && c < n; i++) @(posedge clk_sys);
    chk("wait", 32'(c >= n), 32'h1);
    @(posedge clk_sys);
  endtask : wait_n
  task automatic pulse_halt;
    halt_req <= 1'b1;
    @(posedge clk_sys);
    halt_req <= 1'b0;
  endtask : pulse_halt
  task automatic do_reset(input logic [31:0] id, input logic e, g);
    sys_rst <= 1'b1;
    strap_id <= id;
    strap_ext_topology <= e;
    strap_new_gen <= g;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  initial begin
    {sys_rst, reg_valid, reg_req, t_rx_v, t_rx} = '0;
    {strap_id, strap_ext_topology, strap_new_gen} = '0;
    {halt_req, nmi_req, smi_req, intr_req, snoop_req} = '0;
    stop_clock_request_line = 1'b0;
    peer_prio = 8'h80;
    do_reset(32'h0, 1'b0, 1'b1);
    chk("unit_en", 32'(unit_enabled), 32'h0);
    rchk("spur", ADDR_SPUR_VEC, SPUR_RESET);
    rchk("id", ADDR_LOCAL_ID, 32'h0);
    wait_n(n_f, 1);
    chk("fetch", last_fa, RESET_VECTOR);
    chk("bsp", 32'(bootstrap_processor), 32'h1);
    wr(ADDR_SPUR_VEC, 32'h0000_01FF);
    chk("unit_en", 32'(unit_enabled), 32'h1);
    wr(ADDR_ERR_VEC, 32'hABCD_EF42);
    chk("err_vec", 32'(error_vector), 32'h42);
    rchk("err_word", ADDR_ERR_VEC, 32'hABCD_EF42);
    rchk("unmapped", 32'hFEE0_0400, 32'h0);
    wr(ADDR_CMD_LOW, CMD_INIT_ALL);
    wait_n(n_tx, 1);
    chk("init", 32'(last_tx.kind), 32'(MPBS_MSG_INIT));
    wr(ADDR_CMD_LOW, {CMD_STARTUP_HI, 8'hBD});
    wait_n(n_tx, 2);
    chk("startup_message", 32'(last_tx.vec), 32'hBD);
    send(MPBS_MSG_INIT, 8'h00);
    wait_n(n_f, 2);
    chk("reinit", last_fa, RESET_VECTOR);
    $display("test newer winner done");
    do_reset(32'h1234_5690, 1'b1, 1'b1);
    chk("id32", local_id, 32'h1234_5690);
    rchk("id", ADDR_LOCAL_ID, 32'h9000_0000);
    for (int i = 0; i < 300 && !application_processor; i++)
      @(posedge clk_sys);
    chk("ap", 32'(application_processor), 32'h1);
    chk("bsp", 32'(bootstrap_processor), 32'h0);
    send(MPBS_MSG_STARTUP, 8'hBD);
    wait_n(n_f, 3);
    chk("startup_message_pc", last_fa, 32'h000B_D000);
    send(MPBS_MSG_STARTUP, 8'h22);
    chk("refetch", n_f, 3);
    pulse_halt();
    {intr_req, snoop_req, stop_clock_request_line} <= 3'b111;
    repeat (3) @(posedge clk_sys);
    chk("halt", 32'({halted, snoop_ack, stop_clock_ack}), 32'h7);
    chk("intr", n_w, 0);
    {intr_req, snoop_req, stop_clock_request_line, nmi_req} <= 4'b0001;
    @(posedge clk_sys);
    nmi_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("nmi", 32'({halted, n_w[0]}), 32'h1);
    pulse_halt();
    smi_req <= 1'b1;
    @(posedge clk_sys);
    smi_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("smi", 32'({halted, n_w[1:0]}), 32'h2);
    pulse_halt();
    send(MPBS_MSG_INIT, 8'h00);
    send(MPBS_MSG_STARTUP, 8'h9A);
    wait_n(n_f, 4);
    chk("sipi2", last_fa, 32'h0009_A000);
    send(MPBS_MSG_STARTUP, 8'h9A);
    chk("sipi3", n_f, 4);
    $display("test newer loser done");
    do_reset(32'hABCD_0003, 1'b0, 1'b0);
    chk("id8", local_id, 32'h3);
    wait_n(n_f, 5);
    chk("final_select_message", 32'(last_tx.kind), 32'(MPBS_MSG_FINAL_SEL));
    chk("old_fetch", last_fa, RESET_VECTOR);
    chk("old_bsp", 32'(bootstrap_processor), 32'h1);
    $display("test older select done");
    end_of_test();
  end
endmodule : tb
